// ### pkg/aos_pkg.sv
// shared constants and types of the converter output stage
`default_nettype none
package aos_pkg;
    // pcm sample words
    localparam int SAMPLE_W = 24;
    localparam logic [SAMPLE_W-1:0] SAMP_MAX = 24'h7f_ffff;
    localparam logic [SAMPLE_W-1:0] SAMP_MIN = 24'h80_0000;
    // high-pass corner is fs / HPF_CORNER_DIV; one pole gives fc ~ fs / (2*pi*2^k)
    localparam int HPF_CORNER_DIV = 48000;
    localparam int HPF_SHIFT = $clog2(HPF_CORNER_DIV / 6);
    // word length select {hi, lo} and bits dropped for each length
    localparam logic [1:0] WL_24 = 2'h0;
    localparam logic [1:0] WL_18 = 2'h1;
    localparam logic [1:0] WL_20 = 2'h2;
    localparam logic [1:0] WL_16 = 2'h3;
    localparam logic [4:0] DROP_24 = 5'h0;
    localparam logic [4:0] DROP_18 = 5'h6;
    localparam logic [4:0] DROP_20 = 5'h4;
    localparam logic [4:0] DROP_16 = 5'h8;
    // dither generator: galois lfsr, x^32+x^22+x^2+x+1
    localparam logic [31:0] DITHER_SEED = 32'hace1_2b07;
    localparam logic [31:0] DITHER_TAPS = 32'h8020_0003;
    // one-bit stream rates; the link clock runs at twice the master clock
    localparam int LINK_HZ = 22579200;
    localparam int ONEBIT_RATE_64_HZ = 2822400;
    localparam int ONEBIT_RATE_128_HZ = 5644800;
    localparam int ONEBIT_HALF_64 = LINK_HZ / (2 * ONEBIT_RATE_64_HZ);
    localparam int ONEBIT_HALF_128 = LINK_HZ / (2 * ONEBIT_RATE_128_HZ);
    localparam int OB_CNT_W = $clog2(ONEBIT_HALF_64 + 1);
    // modulator word width and requantiser feedback step
    localparam int MOD_W = 6;
    localparam logic signed [7:0] OB_FULL = 8'sh1f;
    // configuration pins as seen in each clock domain
    typedef struct packed {
        logic mm;
        logic lin_en;
        logic [1:0] wl;
        logic [1:0] byp;
    } aos_ccfg_t;
    typedef struct packed {
        logic mm;
        logic ob_en;
        logic ob_rate;
    } aos_lcfg_t;
    typedef enum logic [1:0] {
        AOS_OB_OFF = 2'b00,
        AOS_OB_LOW = 2'b01,
        AOS_OB_HIGH = 2'b11
    } aos_ob_state_t;
endpackage
`default_nettype wire

// ### pkg/aos_stream_if.sv
// valid/ready word stream between the pcm pipeline and its buffer
`timescale 1ns/1ps
`default_nettype none
interface aos_stream_if #(
    parameter int W = 48
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/aos_hpf.sv
// one-pole dc-removing high-pass for one channel
`timescale 1ns/1ps
`default_nettype none
module aos_hpf #(
    parameter int W = 24,
    parameter int K = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic bypass,
    input wire logic step,
    // sample in, filtered sample out
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y,
    output logic ovf
);
    logic signed [W+K-1:0] dc_q;
    logic signed [W:0] diff;

    // dc estimate keeps k fraction bits: one adder, no multiplier
    assign diff = (W+1)'(x) - (W+1)'($signed(dc_q[W+K-1:K]));

    // output saturates; a saturation is the channel's overflow
    always_comb begin
        ovf = 1'b0;
        y = x;
        if (!bypass) begin
            y = diff[W-1:0];
            if (diff[W] != diff[W-1]) begin
                ovf = 1'b1;
                y = diff[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
            end
        end
    end

    // estimate frozen while bypassed so re-enabling starts from the last offset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dc_q <= '0;
        end else if (step && !bypass) begin
            dc_q <= dc_q + (W+K)'(diff);
        end
    end
endmodule // aos_hpf
`default_nettype wire

// ### hw/aos_skid_buf.sv
// two-entry buffer with registered outputs on both sides
`timescale 1ns/1ps
`default_nettype none
module aos_skid_buf #(
    parameter int W = 48
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // filling side
    aos_stream_if.snk up,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic skid_free_q;
    logic [W-1:0] skid_q;

    assign up.ready = skid_free_q;

    // head feeds the consumer; the skid slot catches the word in flight during a stall
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_free_q <= 1'b1;
            skid_q <= '0;
        end else if (!out_valid || out_ready) begin
            out_valid <= !skid_free_q || up.valid;
            out_data <= skid_free_q ? up.data : skid_q;
            skid_free_q <= 1'b1;
        end else if (up.valid && skid_free_q) begin
            skid_q <= up.data;
            skid_free_q <= 1'b0;
        end
    end
endmodule // aos_skid_buf
`default_nettype wire

// ### hw/aos_output_stage.sv
// converter output stage: filtered pcm words, one-bit streams and raw modulator words
// Contract
// - each channel gets a dc-removing high-pass with corner near fs/48000
// - per-channel disable input: low keeps the filter, high bypasses that channel
// - shorter words are made with triangular dither before truncation
// - select {hi,lo}: 00 24 bits, 01 18, 10 20, 11 16
// - left and right overflow outputs go high on an overflow in that channel
// - overflow outputs work only while the pcm path is enabled
// - one-bit engine turns modulator words into bits; always master, clock plus two data
// - pcm and one-bit outputs may run at the same time
// - one-bit bit clock runs at the stream rate, 64 or 128 times 44.1 kHz
// - rate select low gives 64x, high gives 128x
// - one-bit enable low forces bit clock and both data outputs low
// - modulator mode stops pcm and one-bit outputs and turns config pins into outputs
// - modulator words appear on six data outputs, bit 0 least significant
// - modulator mode drives a master clock copy and a word clock at half its rate
// - pcm words are two's complement, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module aos_output_stage (
    // system clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link clock, twice the master clock
    input wire logic link_clk,
    // configuration pins, asynchronous
    input wire logic right_highpass_disable,
    input wire logic left_highpass_disable,
    input wire logic word_length_sel_hi,
    input wire logic word_length_sel_lo,
    input wire logic linear_output_enable,
    input wire logic onebit_output_enable,
    input wire logic onebit_rate_select,
    input wire logic modulator_mode_enable,
    // decimated samples in, clk domain
    input wire logic samp_valid,
    output logic samp_ready,
    input wire logic signed [aos_pkg::SAMPLE_W-1:0] samp_left,
    input wire logic signed [aos_pkg::SAMPLE_W-1:0] samp_right,
    // pcm words out {left, right}, clk domain
    output logic pcm_valid,
    input wire logic pcm_ready,
    output logic [2*aos_pkg::SAMPLE_W-1:0] pcm_data,
    // overflow flags, clk domain
    output logic left_overflow_flag,
    output logic right_overflow_flag,
    // modulator words in, link domain
    input wire logic signed [aos_pkg::MOD_W-1:0] mod_word_left,
    input wire logic signed [aos_pkg::MOD_W-1:0] mod_word_right,
    // one-bit stream out, link domain
    output logic onebit_bit_clock,
    output logic onebit_left_data,
    output logic onebit_right_data,
    // remapped pins in modulator mode, link domain
    output logic [aos_pkg::MOD_W-1:0] mod_data,
    output logic master_clock_copy_out,
    output logic half_rate_word_clock_out,
    output logic remap_oe
);
    import aos_pkg::*;

    // bits dropped for a word length select
    function automatic logic [4:0] wl_drop(input logic [1:0] sel);
        unique case (sel)
            WL_24: wl_drop = DROP_24;
            WL_18: wl_drop = DROP_18;
            WL_20: wl_drop = DROP_20;
            WL_16: wl_drop = DROP_16;
        endcase
    endfunction

    logic [1:0] lrst_q;
    logic link_rst_n;
    aos_lcfg_t lsync1_q, lsync2_q;
    aos_ccfg_t csync1_q, csync2_q;
    logic pcm_on;
    logic ob_on;
    logic step;
    logic st_v_q;
    logic [SAMPLE_W-1:0] drop_mask;
    logic signed [SAMPLE_W-1:0] samp_in [2];
    logic signed [SAMPLE_W-1:0] hpf_y [2];
    logic [1:0] hpf_ovf;
    logic signed [MOD_W-1:0] mod_in [2];
    aos_ob_state_t ob_state_q;
    logic [OB_CNT_W-1:0] ob_cnt_q;
    logic [OB_CNT_W-1:0] ob_half;
    logic ob_clk_q;
    logic ob_fall;
    logic mck_q;
    logic wck_q;
    logic [MOD_W-1:0] mod_q;
    logic oe_q;

    aos_stream_if #(.W(2*SAMPLE_W)) pcm_if ();

    // reset release carried into the link domain
    always_ff @(posedge link_clk) begin
        lrst_q <= {lrst_q[0], reset_n};
    end
    assign link_rst_n = lrst_q[1];

    // link-side pin synchroniser; first stage feeds only the second
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            lsync1_q <= '0;
            lsync2_q <= '0;
        end else begin
            lsync1_q <= {modulator_mode_enable, onebit_output_enable, onebit_rate_select};
            lsync2_q <= lsync1_q;
        end
    end

    // clk-side synchroniser; mode level crosses from the link domain here too
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            csync1_q <= '0;
            csync2_q <= '0;
        end else begin
            csync1_q <= {lsync2_q.mm, linear_output_enable, word_length_sel_hi,
                word_length_sel_lo, right_highpass_disable, left_highpass_disable};
            csync2_q <= csync1_q;
        end
    end

    // modulator mode shuts the pcm path; one-bit runs beside it otherwise
    assign pcm_on = csync2_q.lin_en && !csync2_q.mm;
    assign ob_on = lsync2_q.ob_en && !lsync2_q.mm;

    // ---------------- pcm path, clk domain ----------------
    assign samp_in[0] = samp_left;
    assign samp_in[1] = samp_right;
    assign samp_ready = pcm_if.ready;
    assign step = samp_valid && samp_ready && pcm_on;
    assign drop_mask = ~({SAMPLE_W{1'b1}} << wl_drop(csync2_q.wl));

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [31:0] lfsr_q;
        logic [SAMPLE_W-1:0] u1, u2;
        logic signed [SAMPLE_W+1:0] dsum;
        logic [SAMPLE_W-1:0] word_d;
        logic [SAMPLE_W-1:0] word_q;
        logic sat;
        logic ovf_q;

        aos_hpf #(.W(SAMPLE_W), .K(HPF_SHIFT)) u_hpf (
            .clk(clk),
            .reset_n(reset_n),
            .bypass(csync2_q.byp[ch]),
            .step(step),
            .x(samp_in[ch]),
            .y(hpf_y[ch]),
            .ovf(hpf_ovf[ch])
        );

        // free-running noise; channels get different seeds so dither is uncorrelated
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                lfsr_q <= DITHER_SEED ^ 32'(ch);
            end else begin
                lfsr_q <= (lfsr_q >> 1) ^ (lfsr_q[0] ? DITHER_TAPS : 32'h0);
            end
        end

        // two uniform values summed give a triangular pdf; minus the mean, plus half an lsb
        assign u1 = SAMPLE_W'(lfsr_q[15:0]) & drop_mask;
        assign u2 = SAMPLE_W'(lfsr_q[31:16]) & drop_mask;
        assign dsum = (SAMPLE_W+2)'(hpf_y[ch]) + (SAMPLE_W+2)'(u1) + (SAMPLE_W+2)'(u2)
            - (SAMPLE_W+2)'(drop_mask) + (SAMPLE_W+2)'(drop_mask ^ (drop_mask >> 1));

        // truncate the dithered word, saturating in two's complement
        always_comb begin
            sat = 1'b0;
            word_d = dsum[SAMPLE_W-1:0] & ~drop_mask;
            if (dsum[SAMPLE_W+1:SAMPLE_W-1] != 3'h0 && dsum[SAMPLE_W+1:SAMPLE_W-1] != 3'h7) begin
                sat = 1'b1;
                word_d = dsum[SAMPLE_W+1] ? SAMP_MIN : (SAMP_MAX & ~drop_mask);
            end
        end

        // flag holds for one sample period; off path shows no overflow
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                word_q <= '0;
                ovf_q <= 1'b0;
            end else if (!pcm_on) begin
                ovf_q <= 1'b0;
            end else if (step) begin
                word_q <= word_d;
                ovf_q <= hpf_ovf[ch] || sat;
            end
        end
    end

    // output word waits here until the buffer takes it; no new sample meanwhile
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_v_q <= 1'b0;
        end else if (step) begin
            st_v_q <= 1'b1;
        end else if (pcm_if.ready) begin
            st_v_q <= 1'b0;
        end
    end

    assign pcm_if.valid = st_v_q;
    assign pcm_if.data = {g_ch[0].word_q, g_ch[1].word_q};
    assign left_overflow_flag = g_ch[0].ovf_q;
    assign right_overflow_flag = g_ch[1].ovf_q;

    aos_skid_buf #(.W(2*SAMPLE_W)) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .up(pcm_if),
        .out_valid(pcm_valid),
        .out_ready(pcm_ready),
        .out_data(pcm_data)
    );

    // ---------------- one-bit engine, link domain ----------------
    assign mod_in[0] = mod_word_left;
    assign mod_in[1] = mod_word_right;
    // config comes in as an argument so the assign below follows every change of the pin
    function automatic logic rate_is_high(input aos_lcfg_t cfg);
        rate_is_high = cfg.ob_rate;
    endfunction

    assign ob_half = rate_is_high(lsync2_q) ? OB_CNT_W'(ONEBIT_HALF_128) : OB_CNT_W'(ONEBIT_HALF_64);
    // a switch to 128x after the count has passed the shorter half ends that phase at once rather than running the counter round
    assign ob_fall = (ob_state_q == AOS_OB_HIGH && ob_cnt_q >= ob_half - 1'b1)
        || ob_state_q == AOS_OB_OFF;

    // bit clock generator; master of the stream, nothing comes back from the receiver
    always_ff @(posedge link_clk) begin
        if (!link_rst_n || !ob_on) begin
            ob_state_q <= AOS_OB_OFF;
            ob_cnt_q <= '0;
            ob_clk_q <= 1'b0;
        end else begin
            unique case (ob_state_q)
                AOS_OB_OFF: begin
                    ob_state_q <= AOS_OB_LOW;
                    ob_cnt_q <= '0;
                end
                AOS_OB_LOW: begin
                    if (ob_cnt_q >= ob_half - 1'b1) begin
                        ob_state_q <= AOS_OB_HIGH;
                        ob_cnt_q <= '0;
                        ob_clk_q <= 1'b1;
                    end else begin
                        ob_cnt_q <= ob_cnt_q + 1'b1;
                    end
                end
                AOS_OB_HIGH: begin
                    if (ob_cnt_q >= ob_half - 1'b1) begin
                        ob_state_q <= AOS_OB_LOW;
                        ob_cnt_q <= '0;
                        ob_clk_q <= 1'b0;
                    end else begin
                        ob_cnt_q <= ob_cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // first-order requantiser per channel; data changes with the falling bit clock
    for (genvar ch = 0; ch < 2; ch++) begin : g_ob
        logic signed [7:0] acc_q;
        logic signed [7:0] v;
        logic dat_q;
        assign v = acc_q + 8'(mod_in[ch]);
        always_ff @(posedge link_clk) begin
            if (!link_rst_n || !ob_on) begin
                acc_q <= '0;
                dat_q <= 1'b0;
            end else if (ob_fall) begin
                dat_q <= !v[7];
                acc_q <= v[7] ? v + OB_FULL : v - OB_FULL;
            end
        end
    end

    assign onebit_bit_clock = ob_clk_q;
    assign onebit_left_data = g_ob[0].dat_q;
    assign onebit_right_data = g_ob[1].dat_q;

    // ---------------- modulator output, link domain ----------------
    // pins turn to outputs only after the mode level is synchronised, never glitching mid-word
    always_ff @(posedge link_clk) begin
        if (!link_rst_n || !lsync2_q.mm) begin
            mck_q <= 1'b0;
            wck_q <= 1'b0;
            mod_q <= '0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= 1'b1;
            mck_q <= !mck_q;
            if (mck_q) begin
                wck_q <= !wck_q;
                mod_q <= wck_q ? mod_word_right : mod_word_left;
            end
        end
    end

    assign mod_data = mod_q;
    assign master_clock_copy_out = mck_q;
    assign half_rate_word_clock_out = wck_q;
    assign remap_oe = oe_q;

    // ---------------- checks ----------------
    property p_hpf_bypass;
        @(posedge clk) disable iff (!reset_n)
        step && csync2_q.byp[0] && csync2_q.wl == WL_24 |=> pcm_if.data[47:24] == $past(samp_left);
    endproperty
    a_hpf_bypass: assert property (p_hpf_bypass) else $error("bypassed left word altered");

    property p_wl_low_bits;
        @(posedge clk) disable iff (!reset_n)
        step |=> (g_ch[1].word_q & $past(drop_mask)) == '0 && st_v_q;
    endproperty
    a_wl_low_bits: assert property (p_wl_low_bits) else $error("dropped bits not cleared");

    property p_ovf_cause;
        @(posedge clk) disable iff (!reset_n)
        step && hpf_ovf[0] |=> left_overflow_flag;
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("left overflow missed");

    property p_ovf_off;
        @(posedge clk) disable iff (!reset_n)
        !pcm_on |=> !left_overflow_flag && !right_overflow_flag;
    endproperty
    a_ovf_off: assert property (p_ovf_off) else $error("overflow flag with pcm path off");

    property p_mm_pcm_still;
        @(posedge clk) disable iff (!reset_n)
        csync2_q.mm && samp_valid |=> $stable(pcm_if.data);
    endproperty
    a_mm_pcm_still: assert property (p_mm_pcm_still) else $error("pcm word changed in modulator mode");

    property p_ob_off;
        @(posedge link_clk) disable iff (!link_rst_n)
        !ob_on |=> !onebit_bit_clock && !onebit_left_data && !onebit_right_data;
    endproperty
    a_ob_off: assert property (p_ob_off) else $error("one-bit outputs not low when off");

    property p_ob_rate64;
        @(posedge link_clk) disable iff (!link_rst_n)
        $rose(onebit_bit_clock) && ob_on && !lsync2_q.ob_rate ##1 (ob_on && !lsync2_q.ob_rate) [*4]
            |-> !onebit_bit_clock && $past(onebit_bit_clock);
    endproperty
    a_ob_rate64: assert property (p_ob_rate64) else $error("64x bit clock high time wrong");

    property p_mck_copy;
        @(posedge link_clk) disable iff (!link_rst_n)
        $past(lsync2_q.mm) |-> master_clock_copy_out != $past(master_clock_copy_out) && remap_oe;
    endproperty
    a_mck_copy: assert property (p_mck_copy) else $error("master clock copy not toggling");

    property p_wck_half;
        @(posedge link_clk) disable iff (!link_rst_n)
        $past(lsync2_q.mm) && !$past(master_clock_copy_out)
            |-> half_rate_word_clock_out == $past(half_rate_word_clock_out);
    endproperty
    a_wck_half: assert property (p_wck_half) else $error("word clock not at half rate");

    property p_mod_left;
        @(posedge link_clk) disable iff (!link_rst_n)
        $past(lsync2_q.mm) && $past(mck_q) && !$past(wck_q) |-> mod_data == $past(mod_word_left);
    endproperty
    a_mod_left: assert property (p_mod_left) else $error("left modulator word not presented");

    c_wl16: cover property (@(posedge clk) disable iff (!reset_n) step && csync2_q.wl == WL_16);
    c_stall: cover property (@(posedge clk) disable iff (!reset_n) pcm_valid && !pcm_ready && !samp_ready);
    c_ob128: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        $rose(onebit_bit_clock) && lsync2_q.ob_rate);
    c_mm: cover property (@(posedge link_clk) disable iff (!link_rst_n) $rose(half_rate_word_clock_out));
endmodule // aos_output_stage
`default_nettype wire

// ### sim/aos_capture.sv
// capture-side model: stalling pcm receiver plus one-bit and modulator stream observers
`timescale 1ns/1ps
`default_nettype none
module aos_capture (
    // clocks
    input wire logic clk,
    input wire logic link_clk,
    // pcm receiver
    input wire logic stall,
    input wire logic pcm_valid,
    input wire logic [47:0] pcm_data,
    output logic pcm_ready,
    output logic [15:0] n_words,
    output logic [47:0] words [16],
    // stream observers
    input wire logic onebit_bit_clock,
    input wire logic onebit_left_data,
    input wire logic onebit_right_data,
    input wire logic master_clock_copy_out,
    input wire logic half_rate_word_clock_out,
    input wire logic [5:0] mod_data,
    output logic [7:0] bper,
    output logic [7:0] mper,
    output logic [7:0] wper,
    output logic bad_edge,
    output logic [5:0] left_word
);
    logic [7:0] bc_q, mc_q, wc_q;
    logic b_q, m_q, w_q, l_q, r_q;
    initial {n_words, bad_edge} = '0;
    // ready is a plain level, so a stall keeps words waiting in the device
    assign pcm_ready = !stall;
    // every handshaken word lands in a ring of sixteen
    always @(posedge clk) begin
        if (pcm_valid && pcm_ready) begin
            words[n_words[3:0]] <= pcm_data;
            n_words <= n_words + 16'h1;
        end
    end
    // periods in link cycles; bits are taken at the rise, so they may move only at a fall
    always @(posedge link_clk) begin
        {b_q, m_q, w_q} <= {onebit_bit_clock, master_clock_copy_out, half_rate_word_clock_out};
        {l_q, r_q} <= {onebit_left_data, onebit_right_data};
        bc_q <= (onebit_bit_clock && !b_q) ? 8'h01 : bc_q + 8'h01;
        mc_q <= (master_clock_copy_out && !m_q) ? 8'h01 : mc_q + 8'h01;
        wc_q <= (half_rate_word_clock_out && !w_q) ? 8'h01 : wc_q + 8'h01;
        if (onebit_bit_clock && !b_q) bper <= bc_q;
        if (master_clock_copy_out && !m_q) mper <= mc_q;
        if (half_rate_word_clock_out && !w_q) wper <= wc_q;
        if (half_rate_word_clock_out) left_word <= mod_data;
        if (onebit_bit_clock && b_q && {onebit_left_data, onebit_right_data} != {l_q, r_q}) bad_edge <= 1'b1;
    end
endmodule // aos_capture
`default_nettype wire

// ### sim/test_adc_output_stage_modes.sv
// self-checking bench for the converter output stage
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_stage_modes;
    import aos_pkg::*;
    logic clk = 0, link_clk = 0, reset_n = 0, stall = 0, samp_valid = 0;
    logic right_highpass_disable = 1, left_highpass_disable = 1, word_length_sel_hi = 0, word_length_sel_lo = 0;
    logic linear_output_enable = 1, onebit_output_enable = 1, onebit_rate_select = 0, modulator_mode_enable = 0;
    logic samp_ready, pcm_valid, pcm_ready, left_overflow_flag, right_overflow_flag, bad_edge;
    logic signed [SAMPLE_W-1:0] samp_left = 0, samp_right = 0;
    logic signed [MOD_W-1:0] mod_word_left = 6'h15, mod_word_right = 6'h2a;
    logic [2*SAMPLE_W-1:0] pcm_data, w;
    logic onebit_bit_clock, onebit_left_data, onebit_right_data;
    logic master_clock_copy_out, half_rate_word_clock_out, remap_oe;
    logic [MOD_W-1:0] mod_data, left_word;
    logic [47:0] words [16];
    logic [15:0] n_words;
    logic [7:0] bper, mper, wper;
    logic [23:0] m;
    int err_count = 0, n_tests = 0, acc, t, d;
    int drops[4] = '{0, 6, 4, 8};
    // clocks, unrelated in phase
    always #2 clk = ~clk;
    always #3 link_clk = ~link_clk;
    aos_output_stage aos_output_stage_i (.*);
    aos_capture aos_capture_i (.*);
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // offer one pair until taken or given up after twenty cycles
    task automatic send(input logic [23:0] l, input logic [23:0] r, output int taken);
        int k;
        k = 0;
        @(negedge clk);
        {samp_valid, samp_left, samp_right} = {1'b1, l, r};
        while (samp_ready !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        taken = int'(k < 20);
        @(negedge clk);
        samp_valid = 0;
    endtask
    task automatic wait_words(input int n);
        int k;
        k = 0;
        while (n_words < n && k < 100) begin
            @(negedge clk);
            k++;
        end
        chk(48'(n_words), 48'(n));
        w = words[n_words[3:0] - 4'h1];
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // cut a hang short long after the tests should be over
    initial begin
        #100us;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1;
        @(negedge clk);
        chk({samp_ready, pcm_valid}, 2'h2);
        repeat (4) @(negedge clk);
        // bypassed full-length pair comes out untouched, left in the upper half
        send(24'h7f0001, 24'h80fffe, t);
        wait_words(1);
        chk(w, 48'h7f0001_80fffe);
        // receiver stalls: buffer fills and refuses, then drains in order, one-bit running
        stall = 1;
        acc = 0;
        for (int i = 1; i < 7; i++) begin
            send(24'(i), 24'(i * 3), t);
            acc += t;
        end
        chk(48'(acc >= 2 && acc < 6), 48'h1);
        stall = 0;
        wait_words(1 + acc);
        for (int i = 1; i <= acc; i++) chk(words[i], {24'(i), 24'(i * 3)});
        chk(bper, 8'h08);
        onebit_rate_select = 1;
        repeat (30) @(negedge clk);
        chk(bper, 8'h04);
        chk(bad_edge, 1'h0);
        onebit_output_enable = 0;
        repeat (8) @(negedge clk);
        repeat (8) begin
            @(negedge link_clk);
            chk({onebit_bit_clock, onebit_left_data, onebit_right_data}, 3'h0);
        end
        // each word length: low bits cleared in both words, right word within dither reach of its input
        for (int c = 0; c < 4; c++) begin
            {word_length_sel_hi, word_length_sel_lo} = 2'(c);
            repeat (4) @(negedge clk);
            acc = n_words;
            send(24'h123457, 24'hedcba9, t);
            wait_words(acc + 1);
            m = (24'h1 << drops[c]) - 24'h1;
            chk(w & {m, m}, 48'h0);
            d = int'($signed(w[23:0])) - int'($signed(24'hedcba9));
            chk(48'(d <= 2 * int'(m) + 2 && d >= -2 * int'(m) - 2), 48'h1);
        end
        {word_length_sel_hi, word_length_sel_lo} = 2'h0;
        // left filter tracks a negative full-scale run, so positive full scale then clips
        left_highpass_disable = 0;
        repeat (4) @(negedge clk);
        acc = n_words;
        repeat (64) send(SAMP_MIN, 24'h000123, t);
        wait_words(acc + 64);
        chk(w[23:0], 24'h000123);
        chk(48'(w[47:24] !== SAMP_MIN), 48'h1);
        send(SAMP_MAX, 24'h000123, t);
        repeat (3) @(negedge clk);
        chk({left_overflow_flag, right_overflow_flag}, 2'h2);
        wait_words(acc + 65);
        chk(w[47:24], SAMP_MAX);
        // pcm off: flags drop and samples are dropped
        linear_output_enable = 0;
        repeat (4) @(negedge clk);
        chk({left_overflow_flag, right_overflow_flag}, 2'h0);
        acc = n_words;
        send(24'h1, 24'h1, t);
        repeat (10) @(negedge clk);
        chk(48'(n_words), 48'(acc));
        // modulator mode: pins become outputs, one-bit and pcm stop
        linear_output_enable = 1;
        onebit_output_enable = 1;
        modulator_mode_enable = 1;
        repeat (20) @(negedge clk);
        chk({remap_oe, onebit_bit_clock, onebit_left_data, onebit_right_data}, 4'h8);
        chk({mper, wper}, 16'h0204);
        chk(left_word, 6'h15);
        acc = n_words;
        send(24'h2, 24'h2, t);
        repeat (10) @(negedge clk);
        chk(48'(n_words), 48'(acc));
        end_sim();
    end
endmodule // test_adc_output_stage_modes
`default_nettype wire
